// ---- rtl/i2crp_pkg.sv ----
package i2crp_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h51;
    localparam logic [7:0] READ_IDLE = 8'hFF;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam int CLK_HZ = 25_000_000;
    localparam int TIMEOUT_MS = 950;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int SCL_HZ = 400_000;
    localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_HZ);
    localparam int REG_DEPTH = 256;
endpackage

// ---- rtl/i2crp_if.sv ----
`timescale 1ns/10ps
interface i2crp_if;
    logic scl_o;
    logic scl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_mst_o;
    logic sda_mst_oe;
    wire logic scl = scl_oe ? scl_o : 1'b1;
    wire logic sda = (sda_dev_oe && !sda_dev_o) ||
        (sda_mst_oe && !sda_mst_o) ? 1'b0 : 1'b1;
    modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport mst (input scl, input sda, output scl_o, output scl_oe,
        output sda_mst_o, output sda_mst_oe);
endinterface

// ---- rtl/i2crp_slave.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Answer at A2h write, A3h read, 400kHz
// - One bit per SCL pulse, sampled high
// - Master changes SDA only while SCL low
// - Both lines released high when idle
// - SDA falling while SCL high is START
// - SDA rising while SCL high is STOP
// - Repeated START equals STOP then START
// - Master finishes transaction within 950 ms
// - Timeout at 950 ms forces standby
// - After timeout: no ACK, reads FFh
// - After timeout only new START resumes
// - Pointer survives STOP and timeout
// - Eight-bit bytes, ninth bit acknowledge
// - Unlimited bytes per transaction
// - Never drive SCL; SDA pull-down only
// - First byte after START is address
// - Master starts only on idle bus
// - Acknowledge only address 1010001b, MSB first
// - Write: first byte pointer, then data
// - Direct read starts at pointer, one past last access
// - Master NACK ends read; release SDA
module i2crp_slave #(
    parameter int TIMEOUT_CYC = i2crp_pkg::TIMEOUT_CYC
) (
    input wire logic clock_i, // Core clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic enable_i, // Clock enable
    i2crp_if.dev bus, // Two-wire bus
    output logic [7:0] wr_data_o, // Written byte
    output logic [7:0] wr_addr_o, // Register of written byte
    output logic wr_valid_o, // Written byte valid
    input wire logic wr_ready_i, // User takes written byte
    output logic [7:0] ptr_o, // Register pointer
    output logic timeout_o // Bus timeout standby
);
    typedef enum logic [2:0] {
        I2CRP_IDLE, I2CRP_ADDR, I2CRP_RXPTR, I2CRP_RXDATA, I2CRP_TX,
        I2CRP_TXACK
    } i2crp_state_t;

    logic [1:0] scl_sync_q, sda_sync_q;
    logic scl_q, sda_q;
    i2crp_state_t state_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q, ptr_q;
    logic ack_phase_q, acked_q, sda_pull_q, timeout_q, active_q;
    logic [31:0] tmo_q;
    logic [7:0] regs_q [i2crp_pkg::REG_DEPTH];
    logic [7:0] buf_data_q [2];
    logic [7:0] buf_addr_q [2];
    logic [1:0] buf_cnt_q;
    logic buf_wr_q, buf_rd_q;
    logic scl_rise, scl_fall, start_c, stop_c, push_c, buf_ready;

    // Two stages before any logic looks at the pins
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (enable_i) begin
            scl_sync_q <= {scl_sync_q[0], bus.scl};
            sda_sync_q <= {sda_sync_q[0], bus.sda};
            scl_q <= scl_sync_q[1];
            sda_q <= sda_sync_q[1];
        end
    end

    assign scl_rise = scl_sync_q[1] && !scl_q;
    assign scl_fall = !scl_sync_q[1] && scl_q;
    assign start_c = scl_sync_q[1] && scl_q && sda_q && !sda_sync_q[1];
    assign stop_c = scl_sync_q[1] && scl_q && !sda_q && sda_sync_q[1];
    assign buf_ready = buf_cnt_q != 2'd2;

    // Transaction timer, runs from START until STOP or until it reaches TIMEOUT_CYC - 1
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tmo_q <= 32'h0000_0000;
            active_q <= 1'b0;
            timeout_q <= 1'b0;
        end else if (enable_i) begin
            if (start_c) begin
                tmo_q <= 32'h0000_0000;
                active_q <= 1'b1;
                timeout_q <= 1'b0;
            end else if (stop_c) begin
                active_q <= 1'b0;
            end else if (active_q) begin
                if (tmo_q >= 32'(TIMEOUT_CYC - 1)) begin
                    timeout_q <= 1'b1;
                    active_q <= 1'b0;
                end else begin
                    tmo_q <= tmo_q + 32'h0000_0001;
                end
            end
        end
    end

    // Byte engine
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= I2CRP_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ack_phase_q <= 1'b0;
            acked_q <= 1'b0;
            sda_pull_q <= 1'b0;
            ptr_q <= i2crp_pkg::PTR_RESET;
            push_c <= 1'b0;
        end else if (enable_i) begin
            push_c <= 1'b0;
            if (start_c) begin
                state_q <= I2CRP_ADDR;
                bit_q <= 4'h0;
                ack_phase_q <= 1'b0;
                sda_pull_q <= 1'b0;
            end else if (stop_c || timeout_q && state_q != I2CRP_IDLE ||
                    (active_q && tmo_q >= 32'(TIMEOUT_CYC - 1))) begin
                state_q <= I2CRP_IDLE;
                sda_pull_q <= 1'b0;
            end else if (state_q != I2CRP_IDLE) begin
                if (scl_rise && !ack_phase_q) begin
                    // Transmit bits move out on the fall, not in on the rise
                    if (state_q != I2CRP_TX) begin
                        shift_q <= {shift_q[6:0], sda_sync_q[1]};
                    end
                    bit_q <= bit_q + 4'h1;
                end
                if (scl_rise && ack_phase_q && state_q == I2CRP_TXACK) begin
                    acked_q <= !sda_sync_q[1];
                end
                if (scl_fall) begin
                    if (ack_phase_q) begin
                        ack_phase_q <= 1'b0;
                        bit_q <= 4'h0;
                        sda_pull_q <= 1'b0;
                        if (state_q == I2CRP_TXACK) begin
                            if (acked_q) begin
                                state_q <= I2CRP_TX;
                                sda_pull_q <= !regs_q[ptr_q][7];
                                shift_q <= {regs_q[ptr_q][6:0], 1'b1};
                                ptr_q <= ptr_q + 8'h01;
                            end else begin
                                state_q <= I2CRP_IDLE;
                            end
                        end else if (state_q == I2CRP_TX) begin
                            sda_pull_q <= !regs_q[ptr_q][7];
                            shift_q <= {regs_q[ptr_q][6:0], 1'b1};
                            ptr_q <= ptr_q + 8'h01;
                        end
                    end else if (state_q == I2CRP_TX) begin
                        if (bit_q == 4'd8) begin
                            state_q <= I2CRP_TXACK;
                            ack_phase_q <= 1'b1;
                            sda_pull_q <= 1'b0;
                        end else begin
                            sda_pull_q <= !shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b1};
                        end
                    end else if (bit_q == 4'd8) begin
                        ack_phase_q <= 1'b1;
                        case (state_q)
                            I2CRP_ADDR: begin
                                if (shift_q[7:1] == i2crp_pkg::SLAVE_ADDR &&
                                        !timeout_q) begin
                                    sda_pull_q <= 1'b1;
                                    state_q <= shift_q[0] ? I2CRP_TX
                                        : I2CRP_RXPTR;
                                    bit_q <= 4'h0;
                                end else begin
                                    state_q <= I2CRP_IDLE;
                                end
                            end
                            I2CRP_RXPTR: begin
                                ptr_q <= shift_q;
                                sda_pull_q <= 1'b1;
                                state_q <= I2CRP_RXDATA;
                            end
                            I2CRP_RXDATA: begin
                                sda_pull_q <= buf_ready;
                                push_c <= buf_ready;
                                if (buf_ready) begin
                                    ptr_q <= ptr_q + 8'h01;
                                end
                            end
                            default: begin
                                state_q <= I2CRP_IDLE;
                            end
                        endcase
                    end
                end
            end
        end
    end

    // Read starts with the pointer already advanced past the last access
    // Two-entry buffer toward the user; a full buffer withholds the ACK
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buf_cnt_q <= 2'h0;
            buf_wr_q <= 1'b0;
            buf_rd_q <= 1'b0;
        end else if (enable_i) begin
            if (push_c) begin
                buf_wr_q <= !buf_wr_q;
            end
            if (wr_valid_o && wr_ready_i) begin
                buf_rd_q <= !buf_rd_q;
            end
            buf_cnt_q <= buf_cnt_q + 2'(push_c) -
                2'(wr_valid_o && wr_ready_i);
        end
    end

    always_ff @(posedge clock_i) begin
        if (enable_i && push_c) begin
            buf_data_q[buf_wr_q] <= shift_q;
            buf_addr_q[buf_wr_q] <= ptr_q - 8'h01;
            regs_q[ptr_q - 8'h01] <= shift_q;
        end
    end

    assign wr_valid_o = buf_cnt_q != 2'h0;
    assign wr_data_o = buf_data_q[buf_rd_q];
    assign wr_addr_o = buf_addr_q[buf_rd_q];
    assign ptr_o = ptr_q;
    assign timeout_o = timeout_q;
    // Drive low only; reads after timeout never get here, bus floats FFh
    assign bus.sda_dev_o = 1'b0;
    assign bus.sda_dev_oe = sda_pull_q && !timeout_q;
endmodule

// ---- rtl/i2crp_master.sv ----
`timescale 1ns/10ps
module i2crp_master (
    input wire logic clock_i, // Core clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic enable_i, // Clock enable
    i2crp_if.mst bus, // Two-wire bus
    input wire logic cmd_valid_i, // Start a byte command
    input wire logic cmd_start_i, // Send START before byte
    input wire logic cmd_stop_i, // Send STOP after byte
    input wire logic cmd_read_i, // Read a byte instead of write
    input wire logic cmd_nack_i, // NACK the read byte
    input wire logic [7:0] cmd_data_i, // Byte to write
    output logic cmd_ready_o, // Command accepted
    output logic [7:0] rd_data_o, // Byte read
    output logic ack_o, // Acknowledge seen
    output logic done_o // Byte finished pulse
);
    typedef enum logic [2:0] {
        I2CRP_M_IDLE, I2CRP_M_START, I2CRP_M_BIT, I2CRP_M_STOP
    } i2crp_mst_t;

    i2crp_mst_t state_q;
    logic [15:0] cnt_q;
    logic [3:0] bit_q;
    logic phase_q, scl_low_q, sda_low_q, stop_q, read_q, nack_q;
    logic [7:0] shift_q;
    logic [1:0] sda_sync_q;
    logic tick;

    assign tick = cnt_q == 16'(i2crp_pkg::SCL_HALF_CYC - 1);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_sync_q <= 2'h3;
        end else if (enable_i) begin
            sda_sync_q <= {sda_sync_q[0], bus.sda};
        end
    end

    // Master moves SDA only while SCL is low, except for START and STOP, which move it while SCL is high
    // Releases both lines after STOP; between bytes without STOP it holds SCL low
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= I2CRP_M_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 4'h0;
            phase_q <= 1'b0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            stop_q <= 1'b0;
            read_q <= 1'b0;
            nack_q <= 1'b0;
            shift_q <= 8'h00;
            rd_data_o <= 8'h00;
            ack_o <= 1'b0;
            done_o <= 1'b0;
        end else if (enable_i) begin
            done_o <= 1'b0;
            cnt_q <= tick ? 16'h0000 : cnt_q + 16'h0001;
            case (state_q)
                I2CRP_M_IDLE: begin
                    cnt_q <= 16'h0000;
                    if (cmd_valid_i) begin
                        stop_q <= cmd_stop_i;
                        read_q <= cmd_read_i;
                        nack_q <= cmd_nack_i;
                        shift_q <= cmd_read_i ? 8'hFF : cmd_data_i;
                        bit_q <= 4'h0;
                        phase_q <= 1'b0;
                        state_q <= cmd_start_i ? I2CRP_M_START
                            : I2CRP_M_BIT;
                    end
                end
                I2CRP_M_START: if (tick) begin
                    phase_q <= !phase_q;
                    if (!phase_q) begin
                        sda_low_q <= 1'b0;
                        scl_low_q <= 1'b0;
                    end else if (sda_low_q == 1'b0 && !scl_low_q) begin
                        sda_low_q <= 1'b1;
                        phase_q <= 1'b0;
                        state_q <= I2CRP_M_STOP;
                        stop_q <= stop_q;
                    end
                end
                I2CRP_M_STOP: if (tick) begin
                    if (sda_low_q && !scl_low_q && bit_q == 4'h0 &&
                            !phase_q) begin
                        scl_low_q <= 1'b1;
                        phase_q <= 1'b0;
                        state_q <= I2CRP_M_BIT;
                    end else begin
                        phase_q <= !phase_q;
                        if (!phase_q) begin
                            scl_low_q <= 1'b0;
                        end else begin
                            sda_low_q <= 1'b0;
                            state_q <= I2CRP_M_IDLE;
                        end
                    end
                end
                I2CRP_M_BIT: if (tick) begin
                    phase_q <= !phase_q;
                    if (!phase_q) begin
                        scl_low_q <= 1'b1;
                        if (bit_q < 4'd8) begin
                            sda_low_q <= !shift_q[7];
                        end else begin
                            sda_low_q <= read_q && !nack_q;
                        end
                    end else if (scl_low_q) begin
                        scl_low_q <= 1'b0;
                        phase_q <= 1'b1;
                    end else begin
                        scl_low_q <= 1'b1;
                        phase_q <= 1'b0;
                        if (bit_q < 4'd8) begin
                            shift_q <= {shift_q[6:0], sda_sync_q[1]};
                            bit_q <= bit_q + 4'h1;
                        end else begin
                            ack_o <= !sda_sync_q[1];
                            rd_data_o <= shift_q;
                            done_o <= 1'b1;
                            state_q <= stop_q ? I2CRP_M_STOP
                                : I2CRP_M_IDLE;
                            sda_low_q <= stop_q;
                            bit_q <= 4'h1;
                        end
                    end
                end
                default: state_q <= I2CRP_M_IDLE;
            endcase
        end
    end

    assign cmd_ready_o = state_q == I2CRP_M_IDLE;
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = scl_low_q;
    assign bus.sda_mst_o = 1'b0;
    assign bus.sda_mst_oe = sda_low_q;
endmodule

// ---- sim/i2crp_sva.sv ----
`timescale 1ns/10ps
module i2crp_sva #(
    parameter int TIMEOUT_CYC = i2crp_pkg::TIMEOUT_CYC
) (
    input wire logic clock_i, // Core clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic scl, // Resolved clock line
    input wire logic sda, // Resolved data line
    input wire logic sda_dev_o, // Slave data level
    input wire logic sda_dev_oe // Slave data pull enable
);
    logic scl_q, sda_q, first_q, rd_q, act_q, nack_q, busy_q;
    logic [3:0] cnt_q;
    logic [7:0] sr_q, low_q;
    logic [31:0] tmo_q;
    logic start, stop, ninth;
    assign start = scl && scl_q && sda_q && !sda;
    assign stop = scl && scl_q && !sda_q && sda;
    assign ninth = scl && !scl_q && cnt_q == 4'h8;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            low_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            low_q <= scl ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
        end
    end
    // Byte framing as seen on the wires, restarted by every START
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= 4'h0;
            sr_q <= 8'h00;
            first_q <= 1'h0;
        end else if (start) begin
            cnt_q <= 4'h0;
            first_q <= 1'h1;
        end else if (scl && !scl_q) begin
            sr_q <= {sr_q[6:0], sda};
            cnt_q <= ninth ? 4'h0 : cnt_q + 4'h1;
            first_q <= first_q && !ninth;
        end
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_q <= 1'h0;
            act_q <= 1'h0;
            nack_q <= 1'h0;
        end else if (start) begin
            nack_q <= 1'h0;
        end else if (ninth && first_q) begin
            rd_q <= sr_q[0];
            act_q <= !sda;
        end else if (ninth && rd_q && act_q && sda) begin
            nack_q <= 1'h1;
        end
    end
    // Saturates so a stuck bus cannot wrap back into the legal window
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_q <= 1'h0;
            tmo_q <= 32'h0000_0000;
        end else if (start) begin
            busy_q <= 1'h1;
            tmo_q <= 32'h0000_0000;
        end else if (stop) begin
            busy_q <= 1'h0;
        end else if (busy_q && tmo_q != 32'hFFFF_FFFF) begin
            tmo_q <= tmo_q + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    property p_addr_ack;
        ninth && first_q |-> sda == (sr_q[7:1] != i2crp_pkg::SLAVE_ADDR);
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge wrong");
    property p_pull_only;
        sda_dev_oe |-> !sda_dev_o;
    endproperty
    a_pull_only: assert property (p_pull_only)
        else $error("slave drives data high");
    property p_pull_after_fall;
        $rose(sda_dev_oe) |-> !scl && low_q inside {[8'h01:8'h18]};
    endproperty
    a_pull_after_fall: assert property (p_pull_after_fall)
        else $error("slave pull not just after clock fall");
    property p_hold_high;
        scl && scl_q |-> $stable(sda_dev_oe);
    endproperty
    a_hold_high: assert property (p_hold_high)
        else $error("slave pull moved while clock high");
    property p_nack_release;
        nack_q |-> !sda_dev_oe;
    endproperty
    a_nack_release: assert property (p_nack_release)
        else $error("slave drives after master nack");
    property p_stop_release;
        !busy_q |-> !sda_dev_oe;
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("slave drives after stop");
    property p_bus_idle;
        stop |=> (scl && sda) [*4];
    endproperty
    a_bus_idle: assert property (p_bus_idle)
        else $error("bus not idle after stop");
    property p_timeout_quiet;
        busy_q && tmo_q > 32'(TIMEOUT_CYC + 8) |-> !sda_dev_oe;
    endproperty
    a_timeout_quiet: assert property (p_timeout_quiet)
        else $error("slave drives after timeout");
endmodule

// ---- sim/i2c_slave_register_port_tb_top.sv ----
`timescale 1ns/10ps
module i2c_slave_register_port_tb_top;
    typedef struct packed {
        logic [3:0] f; // Start, stop, read, nack
        logic [7:0] d;
        logic ack;
        logic [7:0] rd;
    } i2crp_row_t;
    localparam int TMO = 6000;
    logic clock_i, resetn_i, en, cmd_valid, wr_ready;
    logic [3:0] cmd_f;
    logic [7:0] cmd_d, wr_data, wr_addr, ptr, rd_data;
    logic wr_valid, timeout, cmd_ready, ack, done;
    int errors, checked;
    logic [15:0] wq[$];
    logic [15:0] eq[$];
    i2crp_row_t rows[15];
    i2crp_if u_i2crp_if();
    i2crp_slave #(.TIMEOUT_CYC(TMO)) u_i2crp_slave (.clock_i(clock_i),
        .resetn_i(resetn_i), .enable_i(en), .bus(u_i2crp_if),
        .wr_data_o(wr_data), .wr_addr_o(wr_addr), .wr_valid_o(wr_valid),
        .wr_ready_i(wr_ready), .ptr_o(ptr), .timeout_o(timeout));
    i2crp_master u_i2crp_master (.clock_i(clock_i), .resetn_i(resetn_i),
        .enable_i(en), .bus(u_i2crp_if), .cmd_valid_i(cmd_valid),
        .cmd_start_i(cmd_f[3]), .cmd_stop_i(cmd_f[2]),
        .cmd_read_i(cmd_f[1]), .cmd_nack_i(cmd_f[0]), .cmd_data_i(cmd_d),
        .cmd_ready_o(cmd_ready), .rd_data_o(rd_data), .ack_o(ack),
        .done_o(done));
    i2crp_sva #(.TIMEOUT_CYC(TMO)) u_i2crp_sva (.clock_i(clock_i),
        .resetn_i(resetn_i), .scl(u_i2crp_if.scl), .sda(u_i2crp_if.sda),
        .sda_dev_o(u_i2crp_if.sda_dev_o), .sda_dev_oe(u_i2crp_if.sda_dev_oe));
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic stop_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One byte on the bus; entered and left at a falling clock edge
    task automatic op(input i2crp_row_t r);
        int n;
        n = 0;
        cmd_f = r.f;
        cmd_d = r.d;
        cmd_valid = 1'h1;
        while (cmd_ready !== 1'h1 && n < 3000) begin
            @(negedge clock_i);
            n++;
        end
        @(negedge clock_i);
        cmd_valid = 1'h0;
        while (done !== 1'h1 && n < 3000) begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 3000) errors++;
        if (r.f[1]) cmp_byte(rd_data, r.rd);
        else cmp_bit(ack, r.ack);
        @(negedge clock_i);
    endtask
    // Sampled before the edge's own updates land, as the handshake sees it
    always @(posedge clock_i) begin
        if (wr_valid === 1'h1 && wr_ready === 1'h1) wq.push_back({wr_addr, wr_data});
    end
    initial begin
        clock_i = 1'h0;
        forever #20 clock_i = ~clock_i;
    end
    initial begin
        repeat (50000) @(posedge clock_i);
        errors++;
        stop_test();
    end
    initial begin
        errors = 0;
        checked = 0;
        resetn_i = 1'h0;
        en = 1'h1;
        cmd_valid = 1'h0;
        cmd_f = 4'h0;
        cmd_d = 8'h00;
        wr_ready = 1'h1;
        rows = '{
            '{4'h8, 8'hA2, 1'h1, 8'h00}, // Write address
            '{4'h0, 8'h10, 1'h1, 8'h00}, // Pointer byte
            '{4'h0, 8'h5A, 1'h1, 8'h00}, // Data byte
            '{4'h0, 8'hA5, 1'h1, 8'h00}, // Further data
            '{4'h4, 8'h3C, 1'h1, 8'h00}, // Data then stop
            '{4'h8, 8'hA2, 1'h1, 8'h00},
            '{4'h0, 8'h10, 1'h1, 8'h00},
            '{4'h8, 8'hA3, 1'h1, 8'h00}, // Repeated start
            '{4'h2, 8'h00, 1'h0, 8'h5A}, // Read at pointer
            '{4'h7, 8'h00, 1'h0, 8'hA5}, // Last read nacked
            '{4'h8, 8'hA3, 1'h1, 8'h00}, // Address first
            '{4'h7, 8'h00, 1'h0, 8'h3C}, // Pointer kept
            '{4'hC, 8'hA4, 1'h0, 8'h00}, // Foreign address
            '{4'hC, 8'h23, 1'h0, 8'h00}, // Foreign address
            '{4'hC, 8'h51, 1'h0, 8'h00} // Shifted address
        };
        repeat (20) @(negedge clock_i);
        resetn_i = 1'h1;
        @(negedge clock_i);
        cmp_bit(timeout, 1'h0);
        cmp_bit(wr_valid, 1'h0);
        cmp_bit(u_i2crp_if.sda && u_i2crp_if.scl, 1'h1); // Idle bus
        foreach (rows[i]) op(rows[i]); // Table run
        cmp_bit(timeout, 1'h0); // Short transactions
        op('{4'h8, 8'hA2, 1'h1, 8'h00});
        op('{4'h0, 8'h12, 1'h1, 8'h00});
        repeat (TMO + 100) @(negedge clock_i);
        cmp_bit(timeout, 1'h1); // Standby
        op('{4'h3, 8'h00, 1'h0, i2crp_pkg::READ_IDLE}); // Idle read
        op('{4'h4, 8'h77, 1'h0, 8'h00}); // Ignored write
        op('{4'h8, 8'hA3, 1'h1, 8'h00});
        cmp_bit(timeout, 1'h0); // Cleared by start
        op('{4'h7, 8'h00, 1'h0, 8'h3C}); // Pointer kept
        wr_ready = 1'h0;
        op('{4'h8, 8'hA2, 1'h1, 8'h00});
        op('{4'h0, 8'h20, 1'h1, 8'h00});
        op('{4'h0, 8'h11, 1'h1, 8'h00});
        op('{4'h0, 8'h22, 1'h1, 8'h00});
        op('{4'h4, 8'h33, 1'h0, 8'h00}); // Full buffer refuses the byte
        cmp_bit(wr_valid, 1'h1);
        wr_ready = 1'h1;
        repeat (20) @(negedge clock_i);
        eq = '{16'h105A, 16'h11A5, 16'h123C, 16'h2011, 16'h2122};
        cmp_byte(8'(wq.size()), 8'h05); // Timed out write lost
        foreach (eq[i]) begin
            cmp_byte(wq[i][15:8], eq[i][15:8]); // Register
            cmp_byte(wq[i][7:0], eq[i][7:0]); // Data
        end
        resetn_i = 1'h0;
        repeat (2) @(negedge clock_i);
        cmp_byte(ptr, i2crp_pkg::PTR_RESET);
        cmp_bit(wr_valid, 1'h0);
        resetn_i = 1'h1;
        stop_test();
    end
endmodule
